// ==== sgpc_pkg.sv ====
// Constants, register map and field layout of the serial coding sublayer control block
// Summary of operation
// - Loopback bit returns received data to transmitter
// - Power-save stops receiver and transmitter, PLL stays
// - Negotiation control applies on next advertisement write
// - Role bit: zero MAC-side, one PHY-side
// - Mode field: 00 SerDes, 10 SGMII, resets SGMII
// - Interrupt enable gates completion interrupt output
// - Completion flag sticky until software writes zero
package sgpc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and data widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int CODE_W = 10;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_AN_ADVERT = 24'h1F0004;
    localparam logic [ADDR_W-1:0] IDX_DIG_CTRL = 24'h1F8000;
    localparam logic [ADDR_W-1:0] IDX_AN_CTRL = 24'h1F8001;
    localparam logic [ADDR_W-1:0] IDX_AN_STATUS = 24'h1F8002;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 24'h1F8010;
    localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR = 24'h1F8011;
    localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE = 24'h1F8012;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and writable masks
    localparam logic [REG_W-1:0] DIG_CTRL_RST = 16'h2400;
    localparam logic [REG_W-1:0] AN_CTRL_RST = 16'h0004;
    localparam logic [REG_W-1:0] AN_CTRL_MASK = 16'h001F;
    localparam logic [REG_W-1:0] AN_ADVERT_RST = 16'h0020;
    localparam logic [REG_W-1:0] AN_ADVERT_MASK = 16'hFFE0;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int DIG_LOOPBACK_BIT = 14;
    localparam int DIG_PWRSAVE_BIT = 11;
    localparam int AN_LINKADV_BIT = 4;
    localparam int AN_ROLE_BIT = 3;
    localparam int AN_MODE_MSB = 2;
    localparam int AN_MODE_LSB = 1;
    localparam int AN_INTEN_BIT = 0;
    localparam int ST_COMPLETE_BIT = 0;
    localparam int ST_DUPLEX_BIT = 1;
    localparam int ST_SPEED_LSB = 2;
    localparam int ST_SPEED_MSB = 3;
    localparam int ST_LINK_BIT = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode encodings and interrupt events
    localparam logic [1:0] MODE_SERDES = 2'h0;
    localparam logic [1:0] MODE_SGMII = 2'h2;
    localparam int IRQ_W = 2;
    localparam int IRQ_AN_DONE = 0;
    localparam int IRQ_LINK_CHG = 1;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] sgpc_byte_addr(input logic [ADDR_W-1:0] idx);
        sgpc_byte_addr = {idx[ADDR_W-3:0], 2'h0};
    endfunction : sgpc_byte_addr

endpackage : sgpc_pkg

// ==== sgpc_ctrl_if.sv ====
// Control fields passed from the register bank to the code-group path
interface sgpc_ctrl_if;
    logic loopback;
    logic powerSave;
    modport bank (output loopback, output powerSave);
    modport path (input loopback, input powerSave);
endinterface : sgpc_ctrl_if

// ==== sgpc_code_path.sv ====
// Code-group path with remote loopback and power-save gating
module sgpc_code_path
    import sgpc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Controls from the register bank
    sgpc_ctrl_if.path ctl,
    // Serial side
    input wire logic [sgpc_pkg::CODE_W-1:0] rxCode,
    output logic [sgpc_pkg::CODE_W-1:0] serTxCode,
    // Coding sublayer side
    input wire logic [sgpc_pkg::CODE_W-1:0] txCode,
    output logic [sgpc_pkg::CODE_W-1:0] rxCodeOut,
    // Analogue enables
    output logic rxEnable,
    output logic txEnable,
    output logic pllEnable
);

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit select: loopback returns received groups
    always_ff @(posedge clock) begin
        if (!nrst) begin
            serTxCode <= '0;
        end else if (ctl.powerSave) begin
            serTxCode <= '0;
        end else if (ctl.loopback) begin
            serTxCode <= rxCode;
        end else begin
            serTxCode <= txCode;
        end
    end

    // Receive path to decoder, quiet in power save
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rxCodeOut <= '0;
        end else begin
            rxCodeOut <= ctl.powerSave ? '0 : rxCode;
        end
    end

    // Analogue enables; PLL stays on
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rxEnable <= 1'b0;
            txEnable <= 1'b0;
            pllEnable <= 1'b0;
        end else begin
            rxEnable <= !ctl.powerSave;
            txEnable <= !ctl.powerSave;
            pllEnable <= 1'b1;
        end
    end

endmodule : sgpc_code_path

// ==== sgpc_control.sv ====
// APB register bank and control of the serial coding sublayer
//
// The APB register port was decided locally.
module sgpc_control
    import sgpc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sgpc_pkg::ADDR_W-1:0] paddr,
    input wire logic [sgpc_pkg::DATA_W-1:0] pwdata,
    output logic [sgpc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial code groups
    input wire logic [sgpc_pkg::CODE_W-1:0] rxCode,
    output logic [sgpc_pkg::CODE_W-1:0] serTxCode,
    input wire logic [sgpc_pkg::CODE_W-1:0] txCode,
    output logic [sgpc_pkg::CODE_W-1:0] rxCodeOut,
    // Analogue enables
    output logic rxEnable,
    output logic txEnable,
    output logic pllEnable,
    // Negotiation engine controls
    output logic [1:0] codingSublayerMode,
    output logic roleMaster,
    output logic linkAdvert,
    output logic [sgpc_pkg::REG_W-1:0] advertWord,
    output logic anRestart,
    // Negotiation engine results
    input wire logic anDone,
    input wire logic anLinkUp,
    input wire logic [1:0] anSpeed,
    input wire logic anFullDuplex,
    // Interrupts
    output logic anIntOut,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [REG_W-1:0] digCtrl_q;
    logic [REG_W-1:0] anCtrlStage_q;
    logic [REG_W-1:0] anCtrlLive_q;
    logic [REG_W-1:0] advert_q;
    logic anComplete_q;
    logic linkUp_q;
    logic [1:0] speed_q;
    logic duplex_q;
    logic [IRQ_W-1:0] irqStatus_q;
    logic [IRQ_W-1:0] irqEnable_q;
    logic [IRQ_W-1:0] irqEvent;
    logic access;
    logic wrStrobe;
    logic rdStrobe;
    logic [DATA_W-1:0] rdData_d;
    logic addrHit;
    logic [REG_W-1:0] wrWord;
    logic [REG_W-1:0] statusWord;

    sgpc_ctrl_if ctlBus ();

    ////////////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, read sampled in the wait state, write at the ready edge
    assign access = psel && penable;
    assign wrStrobe = access && pready && pwrite;
    assign rdStrobe = access && !pready && !pwrite;
    assign wrWord = pwdata[REG_W-1:0];

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pready <= 1'b0;
        end else begin
            pready <= access && !pready;
        end
    end

    // Address decode for mapped registers
    always_comb begin
        addrHit = 1'b1;
        case (paddr)
            sgpc_byte_addr(IDX_AN_ADVERT): addrHit = 1'b1;
            sgpc_byte_addr(IDX_DIG_CTRL): addrHit = 1'b1;
            sgpc_byte_addr(IDX_AN_CTRL): addrHit = 1'b1;
            sgpc_byte_addr(IDX_AN_STATUS): addrHit = 1'b1;
            sgpc_byte_addr(IDX_IRQ_STATUS): addrHit = 1'b1;
            sgpc_byte_addr(IDX_IRQ_CLEAR): addrHit = 1'b1;
            sgpc_byte_addr(IDX_IRQ_ENABLE): addrHit = 1'b1;
            default: addrHit = 1'b0;
        endcase
    end

    // Status word view
    always_comb begin
        statusWord = '0;
        statusWord[ST_COMPLETE_BIT] = anComplete_q;
        statusWord[ST_DUPLEX_BIT] = duplex_q;
        statusWord[ST_SPEED_MSB:ST_SPEED_LSB] = speed_q;
        statusWord[ST_LINK_BIT] = linkUp_q;
    end

    // Read data mux; write-only and unmapped read zero
    always_comb begin
        rdData_d = '0;
        case (paddr)
            sgpc_byte_addr(IDX_AN_ADVERT): rdData_d[REG_W-1:0] = advert_q;
            sgpc_byte_addr(IDX_DIG_CTRL): rdData_d[REG_W-1:0] = digCtrl_q;
            sgpc_byte_addr(IDX_AN_CTRL): rdData_d[REG_W-1:0] = anCtrlStage_q & AN_CTRL_MASK;
            sgpc_byte_addr(IDX_AN_STATUS): rdData_d[REG_W-1:0] = statusWord;
            sgpc_byte_addr(IDX_IRQ_STATUS): rdData_d[IRQ_W-1:0] = irqStatus_q;
            sgpc_byte_addr(IDX_IRQ_ENABLE): rdData_d[IRQ_W-1:0] = irqEnable_q;
            default: rdData_d = '0;
        endcase
    end

    // Read data and error response registered with ready
    always_ff @(posedge clock) begin
        if (!nrst) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            prdata <= rdStrobe ? rdData_d : '0;
            pslverr <= !addrHit;
        end else begin
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Digital control: loopback and power save; reserved bits keep their reset value
    always_ff @(posedge clock) begin
        if (!nrst) begin
            digCtrl_q <= DIG_CTRL_RST;
        end else if (wrStrobe && paddr == sgpc_byte_addr(IDX_DIG_CTRL)) begin
            digCtrl_q[DIG_LOOPBACK_BIT] <= wrWord[DIG_LOOPBACK_BIT];
            digCtrl_q[DIG_PWRSAVE_BIT] <= wrWord[DIG_PWRSAVE_BIT];
        end
    end

    assign ctlBus.loopback = digCtrl_q[DIG_LOOPBACK_BIT];
    assign ctlBus.powerSave = digCtrl_q[DIG_PWRSAVE_BIT];

    // Staged negotiation control; reserved upper bits dropped
    always_ff @(posedge clock) begin
        if (!nrst) begin
            anCtrlStage_q <= AN_CTRL_RST;
        end else if (wrStrobe && paddr == sgpc_byte_addr(IDX_AN_CTRL)) begin
            anCtrlStage_q <= wrWord & AN_CTRL_MASK;
        end
    end

    // Advertisement write applies staged control and restarts negotiation
    always_ff @(posedge clock) begin
        if (!nrst) begin
            advert_q <= AN_ADVERT_RST;
            anCtrlLive_q <= AN_CTRL_RST;
            anRestart <= 1'b0;
        end else if (wrStrobe && paddr == sgpc_byte_addr(IDX_AN_ADVERT)) begin
            advert_q <= wrWord & AN_ADVERT_MASK;
            anCtrlLive_q <= anCtrlStage_q;
            anRestart <= 1'b1;
        end else begin
            anRestart <= 1'b0;
        end
    end

    // Live negotiation controls to the engine
    always_ff @(posedge clock) begin
        if (!nrst) begin
            codingSublayerMode <= MODE_SGMII;
            roleMaster <= 1'b0;
            linkAdvert <= 1'b0;
            advertWord <= AN_ADVERT_RST;
        end else begin
            codingSublayerMode <= anCtrlLive_q[AN_MODE_MSB:AN_MODE_LSB];
            roleMaster <= anCtrlLive_q[AN_ROLE_BIT];
            linkAdvert <= anCtrlLive_q[AN_LINKADV_BIT];
            advertWord <= advert_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Negotiation results captured on completion
    always_ff @(posedge clock) begin
        if (!nrst) begin
            linkUp_q <= 1'b0;
            speed_q <= 2'h0;
            duplex_q <= 1'b0;
        end else if (anDone) begin
            linkUp_q <= anLinkUp;
            speed_q <= anSpeed;
            duplex_q <= anFullDuplex;
        end
    end

    // Completion flag: set wins over a zero write
    always_ff @(posedge clock) begin
        if (!nrst) begin
            anComplete_q <= 1'b0;
        end else if (anDone) begin
            anComplete_q <= 1'b1;
        end else if (wrStrobe && paddr == sgpc_byte_addr(IDX_AN_STATUS) && !wrWord[ST_COMPLETE_BIT]) begin
            anComplete_q <= 1'b0;
        end
    end

    // Completion interrupt output gated by live enable
    always_ff @(posedge clock) begin
        if (!nrst) begin
            anIntOut <= 1'b0;
        end else begin
            anIntOut <= anComplete_q && anCtrlLive_q[AN_INTEN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt events, sticky status, enable and clear
    assign irqEvent[IRQ_AN_DONE] = anDone;
    assign irqEvent[IRQ_LINK_CHG] = anDone && (anLinkUp != linkUp_q);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            irqStatus_q <= '0;
        end else if (wrStrobe && paddr == sgpc_byte_addr(IDX_IRQ_CLEAR)) begin
            irqStatus_q <= (irqStatus_q & ~wrWord[IRQ_W-1:0]) | irqEvent;
        end else begin
            irqStatus_q <= irqStatus_q | irqEvent;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            irqEnable_q <= '0;
        end else if (wrStrobe && paddr == sgpc_byte_addr(IDX_IRQ_ENABLE)) begin
            irqEnable_q <= wrWord[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_q & irqEnable_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Code-group path
    sgpc_code_path pathInst (
        .clock(clock),
        .nrst(nrst),
        .ctl(ctlBus.path),
        .rxCode(rxCode),
        .serTxCode(serTxCode),
        .txCode(txCode),
        .rxCodeOut(rxCodeOut),
        .rxEnable(rxEnable),
        .txEnable(txEnable),
        .pllEnable(pllEnable)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_loop_returns_rx: assert property (@(posedge clock) disable iff (!nrst)
        digCtrl_q[DIG_LOOPBACK_BIT] && !digCtrl_q[DIG_PWRSAVE_BIT] |=> serTxCode == $past(rxCode))
        else $error("loopback did not return received code group");

    chk_normal_tx_path: assert property (@(posedge clock) disable iff (!nrst)
        !digCtrl_q[DIG_LOOPBACK_BIT] && !digCtrl_q[DIG_PWRSAVE_BIT] |=> serTxCode == $past(txCode))
        else $error("normal transmit path broken");

    chk_pwrsave_off: assert property (@(posedge clock) disable iff (!nrst)
        digCtrl_q[DIG_PWRSAVE_BIT] |=> !rxEnable && !txEnable && pllEnable && serTxCode == '0)
        else $error("power save did not stop receiver and transmitter");

    chk_stage_hold: assert property (@(posedge clock) disable iff (!nrst)
        !(wrStrobe && paddr == sgpc_byte_addr(IDX_AN_ADVERT)) |=> $stable(anCtrlLive_q))
        else $error("negotiation control changed without advertisement write");

    chk_stage_apply: assert property (@(posedge clock) disable iff (!nrst)
        wrStrobe && paddr == sgpc_byte_addr(IDX_AN_ADVERT) |=> anCtrlLive_q == $past(anCtrlStage_q) ##1
        codingSublayerMode == $past(anCtrlStage_q[AN_MODE_MSB:AN_MODE_LSB], 2))
        else $error("staged control not applied after advertisement write");

    chk_role_follow: assert property (@(posedge clock) disable iff (!nrst)
        ##1 roleMaster == $past(anCtrlLive_q[AN_ROLE_BIT]))
        else $error("role output does not follow live control");

    chk_int_gate: assert property (@(posedge clock) disable iff (!nrst)
        anIntOut |-> $past(anComplete_q) && $past(anCtrlLive_q[AN_INTEN_BIT]))
        else $error("completion interrupt without enable or flag");

    chk_flag_sets: assert property (@(posedge clock) disable iff (!nrst)
        anDone |=> anComplete_q)
        else $error("completion flag not set on negotiation done");

    chk_flag_sticky: assert property (@(posedge clock) disable iff (!nrst)
        anComplete_q && !(wrStrobe && paddr == sgpc_byte_addr(IDX_AN_STATUS)) |=> anComplete_q)
        else $error("completion flag cleared without a write");

    chk_reserved_zero: assert property (@(posedge clock) disable iff (!nrst)
        rdStrobe && paddr == sgpc_byte_addr(IDX_AN_CTRL) |=> pready && prdata[REG_W-1:AN_LINKADV_BIT+1] == '0)
        else $error("reserved control bits read nonzero");

    chk_ready_one_wait: assert property (@(posedge clock) disable iff (!nrst)
        $rose(access) |=> pready ##1 !pready)
        else $error("ready not given after one wait state");

endmodule : sgpc_control

// ==== sgpc_partner_model.sv ====
// Far-side model: received code groups and negotiation results
module sgpc_partner_model
    import sgpc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Commands from the bench
    input wire logic kick,
    input wire logic [3:0] lag,
    input wire logic linkIn,
    input wire logic [1:0] speedIn,
    input wire logic duplexIn,
    // Serial side
    output logic [sgpc_pkg::CODE_W-1:0] rxCode,
    // Negotiation results
    output logic anDone,
    output logic anLinkUp,
    output logic [1:0] anSpeed,
    output logic anFullDuplex
);
    timeunit 1ns;
    timeprecision 1ps;

    int seedP = 33165;
    logic busyQ = 1'b0;
    logic [3:0] waitQ = 4'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Quiet outputs at time zero
    initial begin
        rxCode = '0;
        anDone = 1'b0;
        anLinkUp = 1'b0;
        anSpeed = 2'h0;
        anFullDuplex = 1'b0;
    end

    // Fresh code group each cycle; results scrambled outside the pulse so stale values never pass
    always @(posedge clock) begin
        rxCode <= CODE_W'($random(seedP));
        anDone <= 1'b0;
        anLinkUp <= ~anLinkUp;
        anSpeed <= ~anSpeed;
        anFullDuplex <= ~anFullDuplex;
        if (!nrst) begin
            busyQ <= 1'b0;
        end else if (kick) begin
            busyQ <= 1'b1;
            waitQ <= lag;
        end else if (busyQ && waitQ != 4'h0) begin
            waitQ <= waitQ - 4'h1;
        end else if (busyQ) begin
            busyQ <= 1'b0;
            anDone <= 1'b1;
            anLinkUp <= linkIn;
            anSpeed <= speedIn;
            anFullDuplex <= duplexIn;
        end
    end

endmodule : sgpc_partner_model

// ==== sgpc_control_test.sv ====
// Self-checking bench of the coding sublayer control block
module sgpc_control_test
    import sgpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Expected bus answer, noted by the driver
    typedef struct packed {
        logic isRead;
        logic [DATA_W-1:0] data;
        logic err;
    } sgpc_note_t;

    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [CODE_W-1:0] txCode = '0;
    logic kick = 1'b0;
    logic [3:0] lag = 4'h0;
    logic linkIn = 1'b0;
    logic [1:0] speedIn = 2'h0;
    logic duplexIn = 1'b0;
    logic [DATA_W-1:0] prdata;
    logic [CODE_W-1:0] rxCode, serTxCode, rxCodeOut;
    logic [1:0] codingSublayerMode, anSpeed;
    logic [REG_W-1:0] advertWord;
    logic pready, pslverr, rxEnable, txEnable, pllEnable, roleMaster, linkAdvert, anRestart;
    logic anDone, anLinkUp, anFullDuplex, anIntOut, irq;
    int mismatches = 0;
    int checksDone = 0;
    int cycleCount = 0;
    int seed = 33165;
    sgpc_note_t notes[$];
    sgpc_note_t note;
    logic [DATA_W-1:0] w;
    logic [4:0] live;
    logic [4:0] combos [3] = '{5'b11000, 5'b00100, 5'b11101};

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and instances
    always #12.5 clock = ~clock;

    sgpc_control sgpc_control_i (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxCode(rxCode),
        .serTxCode(serTxCode), .txCode(txCode), .rxCodeOut(rxCodeOut), .rxEnable(rxEnable),
        .txEnable(txEnable), .pllEnable(pllEnable), .codingSublayerMode(codingSublayerMode),
        .roleMaster(roleMaster), .linkAdvert(linkAdvert), .advertWord(advertWord), .anRestart(anRestart),
        .anDone(anDone), .anLinkUp(anLinkUp), .anSpeed(anSpeed), .anFullDuplex(anFullDuplex),
        .anIntOut(anIntOut), .irq(irq)
    );

    sgpc_partner_model sgpc_partner_model_i (
        .clock(clock), .nrst(nrst), .kick(kick), .lag(lag), .linkIn(linkIn), .speedIn(speedIn),
        .duplexIn(duplexIn), .rxCode(rxCode), .anDone(anDone), .anLinkUp(anLinkUp), .anSpeed(anSpeed),
        .anFullDuplex(anFullDuplex)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison and verdict
    task automatic cmpBus(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: bus value %h, expected %h", $time, got, exp);
        end
    endtask : cmpBus

    task automatic cmpPin(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask : cmpPin

    task automatic summarize();
        if (mismatches == 0 && checksDone > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // Hang guard
    always @(posedge clock) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 8000) begin
            mismatches++;
            $display("Error at %0t: run did not finish", $time);
            summarize();
        end
    end

    // Oldest note checked against each completed transfer
    always @(posedge clock) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            note = notes.pop_front();
            if (note.isRead) begin
                cmpBus(prdata, note.data);
            end
            cmpBus(32'(pslverr), 32'(note.err));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus master and stimulus helpers
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] wd,
                       input logic [DATA_W-1:0] expData, input logic expErr);
        notes.push_back('{~wr, expData, expErr});
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx[ADDR_W-3:0], 2'h0};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] wd);
        apb(1'b1, idx, wd, '0, 1'b0);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] exp);
        apb(1'b0, idx, '0, exp, 1'b0);
    endtask : rd

    task automatic checkLive(input logic [4:0] l);
        cmpPin(16'(codingSublayerMode), 16'(l[2:1]));
        cmpPin(16'(roleMaster), 16'(l[3]));
        cmpPin(16'(linkAdvert), 16'(l[4]));
    endtask : checkLive

    task automatic runPath(input int cycles, input logic loop, input logic save);
        logic [CODE_W-1:0] prevRx;
        logic [CODE_W-1:0] prevTx;
        @(posedge clock);
        prevRx = rxCode;
        prevTx = txCode;
        txCode <= CODE_W'($random(seed));
        repeat (cycles) begin
            @(posedge clock);
            cmpPin(16'(serTxCode), save ? 16'h0 : loop ? 16'(prevRx) : 16'(prevTx));
            cmpPin(16'(rxCodeOut), save ? 16'h0 : 16'(prevRx));
            prevRx = rxCode;
            prevTx = txCode;
            txCode <= CODE_W'($random(seed));
        end
        cmpPin(16'({rxEnable, txEnable, pllEnable}), {13'h0, ~save, ~save, 1'b1});
    endtask : runPath

    task automatic negotiate(input logic [3:0] lg, input logic lk, input logic [1:0] sp, input logic dp);
        @(posedge clock);
        kick <= 1'b1;
        lag <= lg;
        linkIn <= lk;
        speedIn <= sp;
        duplexIn <= dp;
        @(posedge clock);
        kick <= 1'b0;
        while (anDone !== 1'b1) begin
            @(posedge clock);
        end
        repeat (3) @(posedge clock);
    endtask : negotiate

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
        checkLive(5'b00100);
        rd(IDX_DIG_CTRL, 32'h2400);
        rd(IDX_AN_CTRL, 32'h4);
        rd(IDX_AN_ADVERT, 32'h20);
        rd(IDX_IRQ_STATUS, 32'h0);
        apb(1'b0, 24'h1F8003, '0, '0, 1'b1);
        apb(1'b1, 24'h1F8005, 32'hFFFF, '0, 1'b1);
        // Loopback and power save in every combination, ending in normal operation
        for (int k = 3; k >= 0; k--) begin
            w = $random(seed);
            w[14] = k[0];
            w[11] = k[1];
            wr(IDX_DIG_CTRL, w);
            rd(IDX_DIG_CTRL, {16'h0, DIG_CTRL_RST[15], k[0], DIG_CTRL_RST[13:12], k[1], DIG_CTRL_RST[10:0]});
            runPath(12, k[0], k[1]);
        end
        // Staged negotiation control, legal settings only
        live = 5'b00100;
        foreach (combos[i]) begin
            w = $random(seed);
            wr(IDX_AN_CTRL, {w[31:5], combos[i]});
            rd(IDX_AN_CTRL, {27'h0, combos[i]});
            repeat (2) @(posedge clock);
            cmpPin(16'(anRestart), 16'h0);
            checkLive(live);
            wr(IDX_AN_ADVERT, w);
            @(posedge clock);
            cmpPin(16'(anRestart), 16'h1);
            rd(IDX_AN_ADVERT, {16'h0, w[15:0] & AN_ADVERT_MASK});
            live = combos[i];
            repeat (2) @(posedge clock);
            checkLive(live);
            cmpPin(advertWord, w[15:0] & AN_ADVERT_MASK);
        end
        // Completion with its enable off, then on
        wr(IDX_AN_CTRL, 32'h1C);
        wr(IDX_AN_ADVERT, 32'h20);
        negotiate(4'h0, 1'b1, 2'h2, 1'b1);
        cmpPin(16'(anIntOut), 16'h0);
        rd(IDX_AN_STATUS, 32'h1B);
        rd(IDX_IRQ_STATUS, 32'h3);
        cmpPin(16'(irq), 16'h0);
        wr(IDX_AN_CTRL, 32'h1D);
        repeat (2) @(posedge clock);
        cmpPin(16'(anIntOut), 16'h0);
        wr(IDX_AN_ADVERT, 32'h20);
        repeat (2) @(posedge clock);
        cmpPin(16'(anIntOut), 16'h1);
        wr(IDX_AN_STATUS, 32'h1);
        rd(IDX_AN_STATUS, 32'h1B);
        wr(IDX_AN_STATUS, 32'h0);
        rd(IDX_AN_STATUS, 32'h1A);
        repeat (2) @(posedge clock);
        cmpPin(16'(anIntOut), 16'h0);
        // Interrupt enable, mask and clear for each event
        for (int b = 0; b < 2; b++) begin
            wr(IDX_IRQ_ENABLE, 32'(1 << b));
            repeat (2) @(posedge clock);
            cmpPin(16'(irq), 16'h1);
            rd(IDX_IRQ_ENABLE, 32'(1 << b));
            wr(IDX_IRQ_CLEAR, 32'(1 << b));
            repeat (2) @(posedge clock);
            cmpPin(16'(irq), 16'h0);
            rd(IDX_IRQ_STATUS, b == 0 ? 32'h2 : 32'h0);
        end
        // Slow far side, link unchanged: completion only
        negotiate(4'h9, 1'b1, 2'h1, 1'b0);
        rd(IDX_AN_STATUS, 32'h15);
        cmpPin(16'(anIntOut), 16'h1);
        rd(IDX_IRQ_STATUS, 32'h1);
        summarize();
    end

endmodule : sgpc_control_test
